// ---- hdl/dual_comparator_control.sv ----
`timescale 1ns/10ps
`include "cmp_defines.svh"
// Summary of operation
// - Output is one when positive exceeds negative.
// - Select positive pin, negative pin or reference.
// - Result readable in register, optionally on pin.
// - Per-comparator change flag set on output change.
// - One shared interrupt from enabled set flags.
// - Disabled comparator output forced high.
// - Eight reference levels, one per comparator.
// - Run in idle; total power-down disables both.
// - Unmasked change in idle wakes processor.
// - Auxiliary power bit 5 disables comparators.
module dual_comparator_control
    import cmp_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [`ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte enables.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [`ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [1:0] cmp_raw, // Analog decisions, asynchronous.
    output logic [1:0] cmp_power_en, // Analog core enable.
    output logic [1:0] cmp_pos_sel, // Positive input pin select.
    output logic [1:0] cmp_neg_ref, // Negative input from reference.
    output logic [5:0] cmp_vref_code, // Reference codes, 3 bits each.
    output logic [1:0] cmp_result, // Result to device pins.
    output logic [1:0] cmp_result_oe, // Result pin drive enable.
    input wire logic idle_mode, // Idle mode active.
    input wire logic power_down_mode, // Power-down mode active.
    input wire logic total_power_down, // Total power-down active.
    output logic irq, // Shared comparator interrupt.
    output logic wake_req // Wake request to power control.
);
    ctrl_state_s s_reg;
    ctrl_state_s s_next;
    logic [1:0] ch_en;
    logic [1:0] ch_result;
    logic [1:0] ch_changed;
    logic [1:0] flag_clr;
    logic do_write;
    logic cfg_wr;
    logic cfg_idx;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            cmp_if ch_if ();

            assign ch_en[gi] = s_reg.en[gi] & ~s_reg.cmp_off & ~total_power_down;
            assign ch_if.en = ch_en[gi];
            assign ch_result[gi] = ch_if.result;
            assign ch_changed[gi] = ch_if.changed;

            cmp_channel u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .raw(cmp_raw[gi]),
                .ch(ch_if.chan)
            );

            // Writing zero to the flag bit clears it; the status register clears on one.
            assign flag_clr[gi] = do_write && s_reg.wstrb[0] &&
                ((cfg_wr && cfg_idx == gi && !s_reg.wdata[`CFG_FLAG_BIT]) ||
                 (s_reg.awaddr == `ADDR_INT_STATUS && s_reg.wdata[gi]));

            assign cmp_vref_code[gi*3 +: 3] = s_reg.vref[gi];
        end
    endgenerate

    assign do_write = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    assign cfg_wr = s_reg.awaddr == `ADDR_CFG0 || s_reg.awaddr == `ADDR_CFG1;
    assign cfg_idx = s_reg.awaddr[2];

    assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;

    assign cmp_power_en = ch_en;
    assign cmp_pos_sel = s_reg.pos_sel;
    assign cmp_neg_ref = s_reg.neg_ref;
    assign cmp_result = ch_result;
    assign cmp_result_oe = s_reg.pin_en & ch_en;
    assign irq = |(s_reg.flag & s_reg.mask);
    // Wake is a level; with the clock stopped it still holds from the last edge.
    assign wake_req = irq && (idle_mode || power_down_mode) && !total_power_down;

    always_comb begin
        s_next = s_reg;

        if (s_axi_awvalid && s_axi_awready) begin
            s_next.awaddr = s_axi_awaddr;
            s_next.aw_got = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
            s_next.w_got = 1'b1;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        if (do_write) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `RESP_OKAY;
            if (cfg_wr) begin
                if (s_reg.wstrb[0]) begin
                    s_next.en[cfg_idx] = s_reg.wdata[`CFG_EN_BIT];
                    s_next.pos_sel[cfg_idx] = s_reg.wdata[`CFG_POS_BIT];
                    s_next.neg_ref[cfg_idx] = s_reg.wdata[`CFG_NEGREF_BIT];
                    s_next.pin_en[cfg_idx] = s_reg.wdata[`CFG_PIN_BIT];
                end
            end else begin
                case (s_reg.awaddr)
                    `ADDR_VREF: begin
                        if (s_reg.wstrb[0]) begin
                            s_next.vref[0] = s_reg.wdata[`VREF_W-1:0];
                            s_next.vref[1] = s_reg.wdata[`VREF1_LSB +: `VREF_W];
                        end
                    end
                    `ADDR_INT_STATUS: begin
                    end
                    `ADDR_INT_MASK: begin
                        if (s_reg.wstrb[0]) begin
                            s_next.mask = s_reg.wdata[1:0];
                        end
                    end
                    `ADDR_PWR_AUX: begin
                        if (s_reg.wstrb[0]) begin
                            s_next.cmp_off = s_reg.wdata[`PWR_CMP_OFF_BIT];
                        end
                    end
                    default: begin
                        s_next.bresp = `RESP_SLVERR;
                    end
                endcase
            end
        end

        for (int i = 0; i < 2; i++) begin
            // A change in the clearing cycle keeps the flag set.
            s_next.flag[i] = ch_changed[i] | (s_reg.flag[i] & ~flag_clr[i]);
            s_next.en_prev[i] = ch_en[i];
            if (!ch_en[i]) begin
                s_next.settle[i] = '0;
            end else if (!s_reg.en_prev[i]) begin
                s_next.settle[i] = `SETTLE_CYCLES;
            end else if (s_reg.settle[i] != '0) begin
                s_next.settle[i] = s_reg.settle[i] - `SETTLE_W'(1);
            end
        end

        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `RESP_OKAY;
            s_next.rdata = '0;
            case (s_axi_araddr)
                `ADDR_CFG0, `ADDR_CFG1: begin
                    s_next.rdata[`CFG_EN_BIT] = s_reg.en[s_axi_araddr[2]];
                    s_next.rdata[`CFG_POS_BIT] = s_reg.pos_sel[s_axi_araddr[2]];
                    s_next.rdata[`CFG_NEGREF_BIT] = s_reg.neg_ref[s_axi_araddr[2]];
                    s_next.rdata[`CFG_PIN_BIT] = s_reg.pin_en[s_axi_araddr[2]];
                    s_next.rdata[`CFG_RESULT_BIT] = ch_result[s_axi_araddr[2]];
                    s_next.rdata[`CFG_FLAG_BIT] = s_reg.flag[s_axi_araddr[2]];
                    s_next.rdata[`CFG_SETTLE_BIT] = s_reg.settle[s_axi_araddr[2]] != '0;
                end
                `ADDR_VREF: begin
                    s_next.rdata[`VREF_W-1:0] = s_reg.vref[0];
                    s_next.rdata[`VREF1_LSB +: `VREF_W] = s_reg.vref[1];
                end
                `ADDR_INT_STATUS: begin
                    s_next.rdata[1:0] = s_reg.flag;
                end
                `ADDR_INT_MASK: begin
                    s_next.rdata[1:0] = s_reg.mask;
                end
                `ADDR_PWR_AUX: begin
                    s_next.rdata[`PWR_CMP_OFF_BIT] = s_reg.cmp_off;
                end
                default: begin
                    s_next.rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_changed[0] |=> s_reg.flag[0])
        else $error("change did not set flag 0");

    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.flag[1] && !flag_clr[1] |=> s_reg.flag[1])
        else $error("flag 1 dropped without clear");

    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        flag_clr[0] && !ch_changed[0] |=> !s_reg.flag[0])
        else $error("flag 0 not cleared");

    irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_changed[1] && s_reg.mask[1] |=> irq)
        else $error("masked-in change gave no interrupt");

    irq_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.flag == 2'h0 |-> !irq)
        else $error("interrupt without a flag");

    tpd_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        total_power_down |-> cmp_power_en == 2'h0 ##1 cmp_result == 2'h3 || !total_power_down)
        else $error("total power-down left a comparator on");

    aux_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.cmp_off |-> cmp_power_en == 2'h0)
        else $error("auxiliary power bit did not disable");

    wake_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_changed[0] && s_reg.mask[0] && idle_mode && !total_power_down ##1 idle_mode
        |-> wake_req)
        else $error("no wake on change in idle");

    write_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.aw_got && s_reg.w_got && !s_reg.bvalid |=> s_axi_bvalid)
        else $error("write response missing");

    read_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");

    settle_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_en[0] && !s_reg.en_prev[0] |=> s_reg.settle[0] == `SETTLE_CYCLES)
        else $error("settle count not loaded");

    flag_set1_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_changed[1] |=> s_reg.flag[1])
        else $error("change did not set flag 1");

    flag_hold0_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.flag[0] && !flag_clr[0] |=> s_reg.flag[0])
        else $error("flag 0 dropped without clear");

    flag_clear1_a: assert property (@(posedge clk) disable iff (!rst_n)
        flag_clr[1] && !ch_changed[1] |=> !s_reg.flag[1])
        else $error("flag 1 not cleared");

    irq_follow0_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_changed[0] && s_reg.mask[0] |=> irq)
        else $error("masked-in change 0 gave no interrupt");

    irq_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.mask == 2'h0 |-> !irq)
        else $error("interrupt with both enables off");

    flag_cause0_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_reg.flag[0]) |-> $past(ch_changed[0]))
        else $error("flag 0 set without output change");

    flag_cause1_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_reg.flag[1]) |-> $past(ch_changed[1]))
        else $error("flag 1 set without output change");

    wake_tpd_a: assert property (@(posedge clk) disable iff (!rst_n)
        total_power_down |-> !wake_req)
        else $error("wake request in total power-down");

    wake_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        !idle_mode && !power_down_mode |-> !wake_req)
        else $error("wake request while running");

    wake_pd_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq && power_down_mode && !total_power_down |-> wake_req)
        else $error("no wake in power-down");

    pin_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmp_result_oe & ~cmp_power_en) == 2'h0)
        else $error("result pin driven while disabled");

    vref_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(do_write && s_reg.awaddr == `ADDR_VREF) |=> $stable(cmp_vref_code))
        else $error("reference code changed without write");

    sel_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(do_write && cfg_wr) |=> $stable(cmp_pos_sel) && $stable(cmp_neg_ref))
        else $error("input select changed without write");

    en_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s_reg.cmp_off && !total_power_down |-> cmp_power_en == s_reg.en)
        else $error("enabled comparator not running");

    aux_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_write && s_reg.awaddr == `ADDR_PWR_AUX && s_reg.wstrb[0]
        |=> s_reg.cmp_off == $past(s_reg.wdata[`PWR_CMP_OFF_BIT]))
        else $error("auxiliary power bit not written");

    mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_write && s_reg.awaddr == `ADDR_INT_MASK && s_reg.wstrb[0]
        |=> s_reg.mask == $past(s_reg.wdata[1:0]))
        else $error("interrupt enables not written");

    settle_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ch_en[1] |=> s_reg.settle[1] == '0)
        else $error("settle count kept while disabled");

    settle_load1_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_en[1] && !s_reg.en_prev[1] |=> s_reg.settle[1] == `SETTLE_CYCLES)
        else $error("settle count 1 not loaded");

    result_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_CFG0
        |=> s_axi_rdata[`CFG_RESULT_BIT] == $past(ch_result[0]))
        else $error("read result differs from output");

    disable_flag0_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(ch_en[0]) && !ch_result[0] |=> s_reg.flag[0])
        else $error("disabling low comparator 0 set no flag");

    disable_flag1_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(ch_en[1]) && !ch_result[1] |=> s_reg.flag[1])
        else $error("disabling low comparator 1 set no flag");

    rvalid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule // dual_comparator_control

// ---- hdl/cmp_defines.svh ----
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH
`define ADDR_W 8
`define ADDR_CFG0 8'h00
`define ADDR_CFG1 8'h04
`define ADDR_VREF 8'h08
`define ADDR_INT_STATUS 8'h0c
`define ADDR_INT_MASK 8'h10
`define ADDR_PWR_AUX 8'h14
`define CFG_EN_BIT 0
`define CFG_POS_BIT 1
`define CFG_NEGREF_BIT 2
`define CFG_PIN_BIT 3
`define CFG_RESULT_BIT 4
`define CFG_FLAG_BIT 5
`define CFG_SETTLE_BIT 6
`define VREF_W 3
`define VREF1_LSB 4
`define PWR_CMP_OFF_BIT 5
`define RST_BITS2 2'h0
`define RST_VREF 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_MHZ 100
`define SETTLE_US 10
`define SETTLE_W 10
`define SETTLE_CYCLES 10'(`SETTLE_US * `CLK_MHZ)
`endif

// ---- hdl/cmp_pkg.sv ----
`include "cmp_defines.svh"
package cmp_pkg;
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic result;
    } chan_state_s;

    typedef struct packed {
        logic [`ADDR_W-1:0] awaddr;
        logic aw_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] en;
        logic [1:0] pos_sel;
        logic [1:0] neg_ref;
        logic [1:0] pin_en;
        logic [1:0][`VREF_W-1:0] vref;
        logic [1:0] mask;
        logic cmp_off;
        logic [1:0] flag;
        logic [1:0] en_prev;
        logic [1:0][`SETTLE_W-1:0] settle;
    } ctrl_state_s;
endpackage

// ---- hdl/cmp_if.sv ----
`timescale 1ns/10ps
interface cmp_if;
    logic en;
    logic result;
    logic changed;
    modport ctrl (output en, input result, changed);
    modport chan (input en, output result, changed);
endinterface

// ---- hdl/cmp_channel.sv ----
`timescale 1ns/10ps
module cmp_channel
    import cmp_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset.
    input wire logic raw, // Analog comparator decision.
    cmp_if.chan ch // Link to the control block.
);
    chan_state_s s_reg;
    chan_state_s s_next;

    always_comb begin
        s_next = s_reg;
        s_next.sync1 = raw;
        s_next.sync2 = s_reg.sync1;
        s_next.result = ch.en ? s_reg.sync2 : 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{sync1: 1'b1, sync2: 1'b1, result: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign ch.result = s_reg.result;
    assign ch.changed = s_next.result != s_reg.result;

    disabled_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ch.en |=> ch.result)
        else $error("disabled comparator output not high");

    change_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch.changed |=> ch.result != $past(ch.result))
        else $error("change pulse without output change");

    follows_input_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch.en && $past(ch.en) && $past(ch.en, 2) |-> ##1 ch.result == $past(raw, 3))
        else $error("result does not follow comparator");
endmodule // cmp_channel

// ---- testbench/analog_cmp_model.sv ----
`timescale 1ns/10ps
module analog_cmp_model #(parameter int REF_STEP = 32) (
    input wire logic [1:0] power_en, // Core enables.
    input wire logic [1:0] pos_sel, // Positive pin select.
    input wire logic [1:0] neg_ref, // Negative from reference.
    input wire logic [5:0] vref_code, // Reference codes.
    input wire logic [15:0] pos_a, // Positive pin A levels.
    input wire logic [15:0] pos_b, // Positive pin B levels.
    input wire logic [15:0] neg_pin, // Negative pin levels.
    output logic [1:0] raw // Analog decisions.
);
    logic [1:0] last = 2'h0;
    for (genvar i = 0; i < 2; i++) begin : g_core
        logic [7:0] pv;
        logic [7:0] nv;
        assign pv = pos_sel[i] ? pos_b[8*i+:8] : pos_a[8*i+:8];
        assign nv = neg_ref[i] ? 8'(vref_code[3*i+:3]) * 8'(REF_STEP) : neg_pin[8*i+:8];
        // An unpowered core gives no valid decision, so it shows the inverse of its last one.
        assign raw[i] = power_en[i] ? (pv > nv) : ~last[i];
        always @(raw[i]) begin
            if (power_en[i]) begin
                last[i] = raw[i];
            end
        end
    end
endmodule // analog_cmp_model

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`include "cmp_defines.svh"
module testbench;
    logic clk = 0, rst_n = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req;
    logic [1:0] bresp, rresp, raw, pwr_en, pos_sel, neg_ref, res, res_oe;
    logic [5:0] vref;
    logic idle_mode = 0, power_down_mode = 0, total_power_down = 0;
    logic [15:0] pos_a = 16'h6432, pos_b = 16'h00c8, neg_pin = 16'hfa64;
    int n_errors = 0, num_checks = 0, cycles = 0;

    dual_comparator_control DUT (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmp_raw(raw), .cmp_power_en(pwr_en), .cmp_pos_sel(pos_sel), .cmp_neg_ref(neg_ref),
        .cmp_vref_code(vref), .cmp_result(res), .cmp_result_oe(res_oe),
        .idle_mode(idle_mode), .power_down_mode(power_down_mode),
        .total_power_down(total_power_down), .irq(irq), .wake_req(wake_req));

    analog_cmp_model analog (.power_en(pwr_en), .pos_sel(pos_sel), .neg_ref(neg_ref),
        .vref_code(vref), .pos_a(pos_a), .pos_b(pos_b), .neg_pin(neg_pin), .raw(raw));

    always #5 clk = ~clk;

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `RESP_OKAY);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready) begin
                aw_done = 1;
                awvalid <= 0;
            end
            if (!w_done && wready) begin
                w_done = 1;
                wvalid <= 0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = `RESP_OKAY);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        rd(`ADDR_CFG0, 32'h10);
        rd(`ADDR_CFG1, 32'h10);
        rd(8'h18, 32'h0, `RESP_SLVERR);
        wr(8'h18, 32'h1, `RESP_SLVERR);
        // Comparator 0 enabled with its positive input below the negative pin.
        wr(`ADDR_CFG0, 32'h01);
        repeat (8) @(posedge clk);
        rd(`ADDR_CFG0, 32'h61);
        wr(`ADDR_CFG0, 32'h01);
        rd(`ADDR_CFG0, 32'h41);
        wr(`ADDR_CFG0, 32'h0b);
        repeat (8) @(posedge clk);
        rd(`ADDR_CFG0, 32'h7b);
        chk(32'({res_oe, res, pos_sel}), 32'h1d);
        wr(`ADDR_VREF, 32'h70);
        chk(32'(vref), 32'h38);
        // Comparator 1 compares against its own reference code.
        wr(`ADDR_CFG1, 32'h05);
        repeat (8) @(posedge clk);
        rd(`ADDR_CFG1, 32'h65);
        chk(32'({pwr_en, neg_ref}), 32'he);
        rd(`ADDR_INT_STATUS, 32'h3);
        chk(32'(irq), 32'h0);
        // Interrupts stay masked until both comparators have settled.
        repeat (1000) @(posedge clk);
        rd(`ADDR_CFG1, 32'h25);
        wr(`ADDR_INT_STATUS, 32'h3);
        wr(`ADDR_INT_MASK, 32'h3);
        chk(32'(irq), 32'h0);
        // Comparator 1 now rises above its reference.
        @(posedge clk);
        pos_a <= 16'hf032;
        repeat (8) @(posedge clk);
        chk(32'(irq), 32'h1);
        rd(`ADDR_INT_STATUS, 32'h2);
        wr(`ADDR_INT_STATUS, 32'h1);
        chk(32'(irq), 32'h1);
        wr(`ADDR_INT_STATUS, 32'h2);
        chk(32'(irq), 32'h0);
        // A change while idle must request an interrupt and a wake-up.
        @(posedge clk);
        idle_mode <= 1;
        neg_pin <= 16'hfaff;
        pos_a <= 16'h6432;
        repeat (8) @(posedge clk);
        chk(32'({irq, wake_req}), 32'h3);
        rd(`ADDR_INT_STATUS, 32'h3);
        wr(`ADDR_INT_MASK, 32'h0);
        wr(`ADDR_INT_STATUS, 32'h3);
        wr(`ADDR_PWR_AUX, 32'h20);
        repeat (4) @(posedge clk);
        chk(32'({pwr_en, res}), 32'h3);
        rd(`ADDR_INT_STATUS, 32'h3);
        wr(`ADDR_PWR_AUX, 32'h0);
        // Re-enabled comparators settle again before the interrupt is unmasked.
        repeat (1010) @(posedge clk);
        wr(`ADDR_INT_STATUS, 32'h3);
        wr(`ADDR_INT_MASK, 32'h3);
        rd(`ADDR_INT_STATUS, 32'h0);
        @(posedge clk);
        power_down_mode <= 1;
        total_power_down <= 1;
        repeat (8) @(posedge clk);
        chk(32'({pwr_en, res, irq, wake_req}), 32'he);
        rd(`ADDR_INT_STATUS, 32'h3);
        tally_and_finish();
    end
endmodule // testbench
